// *** verilog/jstc_jog_control.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "jstc_regs.svh"
module jstc_jog_control
	import jstc_pkg::*;
#(
	parameter int MS_CYCLES = `JSTC_MS_NS / `JSTC_CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// command pins, active low
	input wire logic modeSel_b,
	input wire logic fwdJogCmd_b,
	input wire logic revJogCmd_b,
	input wire logic homeCmd_b,
	input wire logic [2:0] jogSpeedSel_b,
	input wire logic runCmd_b,
	// drive status pins
	input wire logic overtravel,
	input wire logic posReached,
	// configuration
	input wire logic speedTorqueCtrl,
	input wire logic [27:0] accelRateParam,
	input wire logic [27:0] decelRateParam,
	input wire logic [4:0] progPattern,
	input wire logic [15:0] eventIntervalMs,
	input wire logic [15:0] stepTimeMs,
	// working table write port
	input wire logic tblWrEn,
	input wire logic [2:0] tblWrIdx,
	input wire logic [27:0] tblWrData,
	input wire logic tableSaveUtility,
	// nonvolatile store
	output logic nvRdEn,
	output logic [2:0] nvIdx,
	input wire logic [27:0] nvRdData,
	output logic nvWrEn,
	output logic [27:0] nvWrData,
	// motion and status outputs
	output logic motorRunOut,
	output logic motorRevOut,
	output logic [27:0] speedRefOut,
	output logic jogActiveOut,
	output logic positionDoneOut,
	output logic [4:0] progOutputs,
	output logic seqErrOut,
	output logic tableReadyOut
);
	logic [`JSTC_PIN_W-1:0] pinRaw;
	logic [`JSTC_PIN_W-1:0] sync1_reg;
	logic [`JSTC_PIN_W-1:0] sync2_reg;
	logic progMode;
	logic fwdOn;
	logic revOn;
	logic homeOn;
	logic runOn;
	logic runOn_reg;
	logic conflict;
	jstc_index_t selIdx;
	jstc_index_t jogIdx_reg;
	jstc_speed_t table_reg [`JSTC_TABLE_DEPTH];
	jstc_jog_e jog_reg;
	jstc_jog_e jog_next;
	jstc_boot_e boot_reg;
	logic [2:0] bootIdx_reg;
	logic bootPend_reg;
	logic [2:0] saveIdx_reg;
	logic saving_reg;
	logic [17:0] msCnt_reg;
	logic progRun_reg;
	jstc_ramp_if rp ();

	// true when two or more of the three motion commands are on
	function automatic logic multi3(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction

	// ================================================
	// input synchronisers
	assign pinRaw = {~modeSel_b, ~fwdJogCmd_b, ~revJogCmd_b, ~homeCmd_b, ~jogSpeedSel_b,
		~runCmd_b, overtravel, posReached};

	generate
		for (genvar i = 0; i < `JSTC_PIN_W; i++) begin : gSync
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					sync1_reg[i] <= 1'b0;
					sync2_reg[i] <= 1'b0;
				end else begin
					sync1_reg[i] <= pinRaw[i];
					sync2_reg[i] <= sync1_reg[i];
				end
			end
		end
	endgenerate

	assign progMode = sync2_reg[`JSTC_PIN_MODE]; // see R3
	assign fwdOn = sync2_reg[`JSTC_PIN_FWD];
	assign revOn = sync2_reg[`JSTC_PIN_REV];
	assign homeOn = sync2_reg[`JSTC_PIN_HOME];
	assign runOn = sync2_reg[`JSTC_PIN_RUN];
	assign selIdx = sync2_reg[`JSTC_PIN_SEL_HI:`JSTC_PIN_SEL_LO]; // see R10
	assign conflict = multi3(fwdOn, revOn, homeOn); // see R7

	// ================================================
	// millisecond tick
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			msCnt_reg <= 18'h00000;
		end else if (msCnt_reg == 18'(MS_CYCLES - 1)) begin
			msCnt_reg <= 18'h00000;
		end else begin
			msCnt_reg <= msCnt_reg + 18'h00001;
		end
	end

	// ================================================
	// speed table, boot load and save
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			boot_reg <= JSTC_LOAD;
			bootIdx_reg <= 3'h0;
			bootPend_reg <= 1'b0;
		end else if (boot_reg == JSTC_LOAD) begin
			// see R15
			bootPend_reg <= 1'b1;
			if (bootPend_reg) begin
				bootIdx_reg <= bootIdx_reg + 3'h1;
				if (bootIdx_reg == 3'h7) begin
					boot_reg <= JSTC_READY;
				end
			end
		end
	end

	generate
		for (genvar e = 0; e < `JSTC_TABLE_DEPTH; e++) begin : gTable
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					table_reg[e] <= `JSTC_SPEED_DEFAULT; // see R9 R11 R14
				end else if (boot_reg == JSTC_LOAD) begin
					if (bootPend_reg && bootIdx_reg == 3'(e)) begin
						table_reg[e] <= nvRdData; // see R15
					end
				end else if (tblWrEn && tblWrIdx == 3'(e) && tblWrData >= `JSTC_SPEED_MIN
					&& tblWrData <= `JSTC_SPEED_MAX) begin
					table_reg[e] <= tblWrData; // see R11
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			saving_reg <= 1'b0;
			saveIdx_reg <= 3'h0;
			nvWrEn <= 1'b0;
			nvWrData <= 28'h0000000;
			nvRdEn <= 1'b0;
			nvIdx <= 3'h0;
		end else begin
			nvRdEn <= (boot_reg == JSTC_LOAD) && !(bootPend_reg && bootIdx_reg == 3'h7);
			nvWrEn <= saving_reg;
			nvWrData <= table_reg[saveIdx_reg];
			if (boot_reg == JSTC_LOAD) begin
				nvIdx <= bootIdx_reg + {2'h0, bootPend_reg};
			end else begin
				nvIdx <= saveIdx_reg;
			end
			if (saving_reg) begin
				saveIdx_reg <= saveIdx_reg + 3'h1;
				saving_reg <= (saveIdx_reg != 3'h7);
			end else if (tableSaveUtility && boot_reg == JSTC_READY) begin
				saving_reg <= 1'b1; // see R14
				saveIdx_reg <= 3'h0;
			end
		end
	end

	// ================================================
	// jog state machine
	always_comb begin
		jog_next = jog_reg;
		case (jog_reg)
			JSTC_IDLE: begin
				if (!progMode && !conflict && boot_reg == JSTC_READY) begin
					if (fwdOn) begin
						jog_next = JSTC_FWD; // see R4
					end else if (revOn) begin
						jog_next = JSTC_REV; // see R5
					end
				end
			end
			JSTC_FWD, JSTC_REV: begin
				if (speedTorqueCtrl && sync2_reg[`JSTC_PIN_OT]) begin
					jog_next = JSTC_LOCKED; // see R8
				end else if (progMode || conflict
					|| (jog_reg == JSTC_FWD ? !fwdOn : !revOn)) begin
					jog_next = JSTC_STOPPING; // see R6 R7
				end
			end
			JSTC_STOPPING: begin
				if (rp.stopped) begin
					jog_next = JSTC_IDLE;
				end
			end
			JSTC_LOCKED: begin
				if (rp.stopped && !fwdOn && !revOn) begin
					jog_next = JSTC_IDLE;
				end
			end
			default: begin
				jog_next = JSTC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			jog_reg <= JSTC_IDLE;
			jogIdx_reg <= 3'h0;
		end else begin
			jog_reg <= jog_next;
			if (jog_reg == JSTC_IDLE && (jog_next == JSTC_FWD || jog_next == JSTC_REV)) begin
				jogIdx_reg <= selIdx; // see R18
			end
		end
	end

	assign rp.target = (jog_reg == JSTC_FWD || jog_reg == JSTC_REV) ? table_reg[jogIdx_reg]
		: 28'h0000000;
	assign rp.accelRate = accelRateParam;
	assign rp.decelRate = decelRateParam;
	assign rp.msTick = (msCnt_reg == 18'h00000);

	jstc_speed_ramp uRamp (
		.clock(clock),
		.rst_b(rst_b),
		.rp(rp)
	);

	// ================================================
	// program table start response
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			runOn_reg <= 1'b0;
			progRun_reg <= 1'b0;
			positionDoneOut <= 1'b1;
			progOutputs <= 5'h00;
			seqErrOut <= 1'b0;
		end else begin
			runOn_reg <= runOn;
			if (!progMode || !runOn) begin
				progRun_reg <= 1'b0;
			end else if (runOn && !runOn_reg && jog_reg == JSTC_IDLE) begin
				if (eventIntervalMs < stepTimeMs) begin
					seqErrOut <= 1'b1; // see R2
					progRun_reg <= 1'b0;
				end else begin
					progRun_reg <= 1'b1; // see R1 R3
					positionDoneOut <= 1'b0;
					progOutputs <= progPattern;
					seqErrOut <= 1'b0;
				end
			end else if (progRun_reg && sync2_reg[`JSTC_PIN_POS]) begin
				progRun_reg <= 1'b0;
				positionDoneOut <= 1'b1;
			end
		end
	end

	// ================================================
	// motion outputs
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			motorRunOut <= 1'b0;
			motorRevOut <= 1'b0;
			speedRefOut <= 28'h0000000;
			jogActiveOut <= 1'b0;
			tableReadyOut <= 1'b0;
		end else begin
			motorRunOut <= progRun_reg || !rp.stopped || jog_reg == JSTC_FWD
				|| jog_reg == JSTC_REV;
			if (jog_reg == JSTC_FWD) begin
				motorRevOut <= 1'b0;
			end else if (jog_reg == JSTC_REV) begin
				motorRevOut <= 1'b1;
			end
			speedRefOut <= rp.curSpeed;
			jogActiveOut <= (jog_reg == JSTC_FWD || jog_reg == JSTC_REV);
			tableReadyOut <= (boot_reg == JSTC_READY);
		end
	end

	// ================================================
	// checks
	sequence runEdge_s;
		runOn && !runOn_reg && progMode && jog_reg == JSTC_IDLE;
	endsequence
	sequence stepOk_s;
		eventIntervalMs >= stepTimeMs;
	endsequence
	sequence stepBad_s;
		eventIntervalMs < stepTimeMs;
	endsequence

	startResponse_a: assert property (@(posedge clock) disable iff (!rst_b) // see R1
		(runEdge_s and stepOk_s) |-> ##[1:3] (motorRunOut && !positionDoneOut))
		else $error("program start response late");
	startPattern_a: assert property (@(posedge clock) disable iff (!rst_b) // see R1
		(runEdge_s and stepOk_s) |=> progOutputs == $past(progPattern))
		else $error("programmable outputs not updated");
	seqError_a: assert property (@(posedge clock) disable iff (!rst_b) // see R2
		(runEdge_s and stepBad_s) |=> (seqErrOut && !progRun_reg))
		else $error("sequence error not raised");
	progNoJog_a: assert property (@(posedge clock) disable iff (!rst_b) // see R3
		(progMode && jog_reg == JSTC_IDLE) |=> jog_reg == JSTC_IDLE)
		else $error("jog started in program mode");
	fwdStart_a: assert property (@(posedge clock) disable iff (!rst_b) // see R4
		(jog_reg == JSTC_IDLE && !progMode && fwdOn && !revOn && !homeOn
		&& boot_reg == JSTC_READY) |=> jog_reg == JSTC_FWD ##1 jogActiveOut)
		else $error("forward jog not started");
	revDirection_a: assert property (@(posedge clock) disable iff (!rst_b) // see R5
		jog_reg == JSTC_REV |=> motorRevOut)
		else $error("reverse jog direction wrong");
	conflictStop_a: assert property (@(posedge clock) disable iff (!rst_b) // see R7
		conflict |=> !(jog_reg == JSTC_FWD || jog_reg == JSTC_REV))
		else $error("motion with conflicting commands");
	overtravelCancel_a: assert property (@(posedge clock) disable iff (!rst_b) // see R8
		((jog_reg == JSTC_FWD || jog_reg == JSTC_REV) && speedTorqueCtrl
		&& sync2_reg[`JSTC_PIN_OT]) |=> jog_reg == JSTC_LOCKED)
		else $error("overtravel did not cancel jog");
	indexHeld_a: assert property (@(posedge clock) disable iff (!rst_b) // see R18
		(jog_reg == JSTC_FWD && $past(jog_reg) == JSTC_FWD) |-> $stable(jogIdx_reg))
		else $error("speed index changed during jog");
	writeRange_a: assert property (@(posedge clock) disable iff (!rst_b) // see R11
		(boot_reg == JSTC_READY && tblWrEn
		&& (tblWrData > `JSTC_SPEED_MAX || tblWrData < `JSTC_SPEED_MIN))
		|=> table_reg[$past(tblWrIdx)] == $past(table_reg[tblWrIdx]))
		else $error("out of range entry accepted");
	bootLength_a: assert property (@(posedge clock) disable iff (!rst_b) // see R15
		$rose(nvRdEn) |-> nvRdEn [*8] ##1 !nvRdEn)
		else $error("boot load not eight reads");
endmodule
`default_nettype wire

// *** verilog/jstc_regs.svh ***
// How it works
// R1 - program start drives motor, done output and programmable outputs within 1 ms
// R2 - event interval shorter than step time raises sequence error, no start
// R3 - mode select active means program table mode, inactive means jog or homing; no homing motion here, the home command only counts toward the R7 conflict
// R4 - forward jog held in jog mode runs motor forward at selected speed
// R5 - reverse jog held in jog mode runs motor reverse at selected speed
// R6 - jog ramps up with accel rate, ramps to stop with decel rate
// R7 - more than one of homing, forward, reverse active gives no motion
// R8 - overtravel under speed or torque control cancels the jog
// R9 - table holds eight jog speed entries, index 0 to 7
// R10 - speed index is the three select inputs, highest input as MSB
// R11 - entries take 1 to 199999999, default 1000, effective when written
// R12 - host changes entries only while the motor is stopped
// R13 - host keeps servo off while writing the working table
// R14 - working table is lost at power loss, only the stored copy remains
// R15 - at every power-up the table loads from nonvolatile storage
// R16 - host drops mode select and waits 1 ms before any jog command
// R17 - host leaves 1 ms between one jog direction and the other
// R18 - speed index sampled when a jog starts, held for the whole motion
`ifndef JSTC_REGS_SVH
`define JSTC_REGS_SVH
`define JSTC_CLK_PERIOD_NS 4
`define JSTC_MS_NS 1000000
`define JSTC_TABLE_DEPTH 8
`define JSTC_SPEED_W 28
`define JSTC_SPEED_MIN 28'h0000001
`define JSTC_SPEED_MAX 28'hBEBC1FF
`define JSTC_SPEED_DEFAULT 28'h00003E8
`define JSTC_PIN_W 10
`define JSTC_PIN_MODE 9
`define JSTC_PIN_FWD 8
`define JSTC_PIN_REV 7
`define JSTC_PIN_HOME 6
`define JSTC_PIN_SEL_HI 5
`define JSTC_PIN_SEL_LO 3
`define JSTC_PIN_RUN 2
`define JSTC_PIN_OT 1
`define JSTC_PIN_POS 0
`endif

// *** verilog/jstc_pkg.sv ***
package jstc_pkg;
	typedef logic [27:0] jstc_speed_t;
	typedef logic [2:0] jstc_index_t;
	typedef enum {JSTC_IDLE, JSTC_FWD, JSTC_REV, JSTC_STOPPING, JSTC_LOCKED} jstc_jog_e;
	typedef enum {JSTC_LOAD, JSTC_READY} jstc_boot_e;
endpackage

// *** verilog/jstc_ramp_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface jstc_ramp_if;
	import jstc_pkg::*;
	jstc_speed_t target;
	jstc_speed_t accelRate;
	jstc_speed_t decelRate;
	logic msTick;
	jstc_speed_t curSpeed;
	logic stopped;
	modport ctrl (output target, accelRate, decelRate, msTick, input curSpeed, stopped);
	modport ramp (input target, accelRate, decelRate, msTick, output curSpeed, stopped);
endinterface
`default_nettype wire

// *** verilog/jstc_speed_ramp.sv ***
`timescale 1ns/1ns
`default_nettype none
module jstc_speed_ramp
	import jstc_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// ramp carrier
	jstc_ramp_if.ramp rp
);
	jstc_speed_t speed_reg;
	jstc_speed_t speed_next;
	logic [28:0] upSum;

	// ================================================
	// speed profile, one step per millisecond
	always_comb begin
		upSum = {1'b0, speed_reg} + {1'b0, rp.accelRate};
		speed_next = speed_reg;
		if (rp.target > speed_reg) begin
			// see R6
			speed_next = (upSum[28] || upSum[27:0] > rp.target) ? rp.target : upSum[27:0];
		end else if (rp.target < speed_reg) begin
			// see R6
			speed_next = (speed_reg - rp.target > rp.decelRate) ? speed_reg - rp.decelRate
				: rp.target;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			speed_reg <= 28'h0000000;
		end else if (rp.msTick) begin
			speed_reg <= speed_next;
		end
	end

	assign rp.curSpeed = speed_reg;
	assign rp.stopped = (speed_reg == 28'h0000000);

	// ================================================
	// checks
	rampNoOvershoot_a: assert property (@(posedge clock) disable iff (!rst_b) // see R6
		(rp.msTick && rp.target > speed_reg) |=> speed_reg <= $past(rp.target))
		else $error("ramp overshot target");
	rampStepLimit_a: assert property (@(posedge clock) disable iff (!rst_b) // see R6
		(rp.msTick && rp.target < speed_reg) |=>
		$past(speed_reg) - speed_reg <= $past(rp.decelRate))
		else $error("deceleration step larger than rate");
endmodule
`default_nettype wire

// *** tb/jstc_nv_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module jstc_nv_model
	import jstc_pkg::*;
(
	// clock
	input wire logic clock,
	// store port
	input wire logic nvRdEn,
	input wire logic [2:0] nvIdx,
	output logic [27:0] nvRdData,
	input wire logic nvWrEn,
	input wire logic [27:0] nvWrData
);
	jstc_speed_t mem [8];
	logic rdLate;
	initial begin
		for (int i = 0; i < 8; i++) begin
			mem[i] = 28'h0000100 + 28'(i);
		end
		rdLate = 1'b0;
	end
	// stored copy survives every reset of the block
	always @(posedge clock) begin
		rdLate <= nvRdEn;
		if (nvWrEn) begin
			mem[nvIdx] <= nvWrData;
		end
	end
	// data valid only around a read, inverted otherwise
	assign nvRdData = (nvRdEn || rdLate) ? mem[nvIdx] : ~mem[nvIdx];
endmodule
`default_nettype wire

// *** tb/tb_jog_speed_table_control.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "jstc_regs.svh"
module tb_jog_speed_table_control
	import jstc_pkg::*;
;
	localparam int MS = 8;
	logic clock = 1'b0, rst_b = 1'b0, modeSel_b = 1'b1, fwd_b = 1'b1, rev_b = 1'b1, home_b = 1'b1;
	logic [2:0] sel_b = 3'h7;
	logic runCmd_b = 1'b1, overtravel = 1'b0, posReached = 1'b0, stCtrl = 1'b1;
	logic [4:0] pattern = 5'h00;
	logic [15:0] evMs = 16'h0000, stepMs = 16'h0000;
	logic tblWrEn = 1'b0, saveReq = 1'b0;
	logic [2:0] tblWrIdx = 3'h0;
	jstc_speed_t tblWrData = 28'h0000000, nvRdData, nvWrData, speedRefOut, tbl [8], v;
	logic nvRdEn, nvWrEn, motorRunOut, motorRevOut, jogActiveOut, positionDoneOut;
	logic seqErrOut, tableReadyOut;
	logic [2:0] nvIdx;
	logic [4:0] progOutputs;
	int n_mismatch = 0, checks = 0;
	int n = 0, t = 0;
	jstc_speed_t accRate = `JSTC_SPEED_MAX, decRate = `JSTC_SPEED_MAX;

	initial begin
		forever #2 clock = ~clock;
	end

	jstc_jog_control #(.MS_CYCLES(MS)) jstc_jog_control_i (.clock(clock), .rst_b(rst_b),
		.modeSel_b(modeSel_b), .fwdJogCmd_b(fwd_b), .revJogCmd_b(rev_b), .homeCmd_b(home_b),
		.jogSpeedSel_b(sel_b), .runCmd_b(runCmd_b), .overtravel(overtravel),
		.posReached(posReached), .speedTorqueCtrl(stCtrl), .accelRateParam(accRate),
		.decelRateParam(decRate), .progPattern(pattern), .eventIntervalMs(evMs),
		.stepTimeMs(stepMs), .tblWrEn(tblWrEn), .tblWrIdx(tblWrIdx), .tblWrData(tblWrData),
		.tableSaveUtility(saveReq), .nvRdEn(nvRdEn), .nvIdx(nvIdx), .nvRdData(nvRdData),
		.nvWrEn(nvWrEn), .nvWrData(nvWrData), .motorRunOut(motorRunOut),
		.motorRevOut(motorRevOut), .speedRefOut(speedRefOut), .jogActiveOut(jogActiveOut),
		.positionDoneOut(positionDoneOut), .progOutputs(progOutputs), .seqErrOut(seqErrOut),
		.tableReadyOut(tableReadyOut));

	jstc_nv_model jstc_nv_model_i (.clock(clock), .nvRdEn(nvRdEn), .nvIdx(nvIdx),
		.nvRdData(nvRdData), .nvWrEn(nvWrEn), .nvWrData(nvWrData));

	// ==========================================
	// compare and report
	task automatic cmpB(input logic g, input logic e, input string m);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task automatic cmpS(input jstc_speed_t g, input jstc_speed_t e, input string m);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %0h exp %0h", $time, m, g, e);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	function automatic jstc_speed_t rndSpeed();
		return 28'(28'h0000001 + ($urandom % `JSTC_SPEED_MAX));
	endfunction

	// millisecond steps a ramp needs to cover a speed at a given rate
	function automatic int ticksFor(input jstc_speed_t target, input jstc_speed_t rate);
		return (int'(target) + int'(rate) - 1) / int'(rate);
	endfunction

	// ==========================================
	// stimulus helpers
	task automatic doReset();
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		@(negedge clock);
		cmpB(positionDoneOut, 1'b1, "reset done level");
		cmpB(motorRunOut, 1'b0, "reset run level");
		@(posedge clock);
		rst_b <= 1'b1;
		for (int k = 0; k < 50 && tableReadyOut !== 1'b1; k++) @(negedge clock);
		cmpB(tableReadyOut, 1'b1, "boot load");
	endtask

	task automatic wr(input jstc_index_t i, input jstc_speed_t d);
		// only written while the motor stands
		@(posedge clock);
		tblWrEn <= 1'b1;
		tblWrIdx <= i;
		tblWrData <= d;
		@(posedge clock);
		tblWrEn <= 1'b0;
	endtask

	task automatic jog(input logic rev, input jstc_index_t i, input logic home, input logic ok);
		@(posedge clock);
		sel_b <= ~i;
		home_b <= ~home;
		@(posedge clock);
		if (rev) rev_b <= 1'b0;
		else fwd_b <= 1'b0;
		repeat (5 * MS) @(posedge clock);
		sel_b <= i;
		repeat (2 * MS) @(posedge clock);
		@(negedge clock);
		cmpB(jogActiveOut, ok, "jog state");
		cmpB(motorRunOut, ok, "motor run");
		if (ok) cmpB(motorRevOut, rev, "direction");
		if (ok) cmpS(speedRefOut, tbl[i], "jog speed");
		@(posedge clock);
		fwd_b <= 1'b1;
		rev_b <= 1'b1;
		home_b <= 1'b1;
		for (int k = 0; k < 100 && motorRunOut !== 1'b0; k++) @(negedge clock);
		cmpB(motorRunOut, 1'b0, "stopped");
		cmpS(speedRefOut, 28'h0000000, "speed zero");
		repeat (MS + 2) @(posedge clock); // gap between directions
	endtask

	// ==========================================
	// tests
	initial begin
		#200000;
		n_mismatch++;
		$display("[FAIL] %0t watchdog expired", $time);
		test_done();
	end

	initial begin
		v = 28'(0 + $urandom(32'h8B0B));
		for (int i = 0; i < 8; i++) tbl[i] = 28'h0000100 + 28'(i);
		doReset();
		jog(1'b0, 3'h7, 1'b0, 1'b1);
		jog(1'b1, 3'h0, 1'b0, 1'b1);
		$display("test boot table done");
		repeat (6) jog(1'(($urandom)), 3'($urandom), 1'b0, 1'b1);
		$display("test random jog done");
		jog(1'b0, 3'h3, 1'b1, 1'b0);
		jog(1'b1, 3'h3, 1'b1, 1'b0);
		@(posedge clock);
		modeSel_b <= 1'b0;
		jog(1'b0, 3'h1, 1'b0, 1'b0);
		modeSel_b <= 1'b1;
		repeat (MS + 2) @(posedge clock);
		$display("test refusal done");
		v = rndSpeed();
		wr(3'h2, v);
		tbl[2] = v;
		wr(3'h3, 28'h0000000);
		wr(3'h3, 28'hFFFFFFF);
		jog(1'b0, 3'h2, 1'b0, 1'b1);
		jog(1'b1, 3'h3, 1'b0, 1'b1);
		@(posedge clock);
		saveReq <= 1'b1;
		@(posedge clock);
		saveReq <= 1'b0;
		repeat (16) @(posedge clock);
		wr(3'h2, rndSpeed());
		doReset();
		jog(1'b0, 3'h2, 1'b0, 1'b1);
		$display("test table save done");
		accRate <= 28'h0000040;
		decRate <= 28'h0000020;
		@(posedge clock);
		sel_b <= ~3'h1;
		@(posedge clock);
		fwd_b <= 1'b0;
		n = 0;
		while (n < 200 && speedRefOut !== tbl[1]) begin
			@(negedge clock);
			n++;
		end
		t = ticksFor(tbl[1], 28'h0000040);
		cmpB(n >= (t - 1) * MS + 4 && n <= t * MS + 6, 1'b1, "ramp up time");
		@(posedge clock);
		fwd_b <= 1'b1;
		n = 0;
		while (n < 200 && motorRunOut !== 1'b0) begin
			@(negedge clock);
			n++;
		end
		t = ticksFor(tbl[1], 28'h0000020);
		cmpB(n >= (t - 1) * MS + 4 && n <= t * MS + 8, 1'b1, "ramp down time");
		@(posedge clock);
		accRate <= `JSTC_SPEED_MAX;
		decRate <= `JSTC_SPEED_MAX;
		repeat (MS + 2) @(posedge clock);
		$display("test ramp done");
		@(posedge clock);
		fwd_b <= 1'b0;
		repeat (4 * MS) @(posedge clock);
		overtravel <= 1'b1;
		repeat (6) @(posedge clock);
		@(negedge clock);
		cmpB(jogActiveOut, 1'b0, "overtravel cancel");
		@(posedge clock);
		fwd_b <= 1'b1;
		overtravel <= 1'b0;
		repeat (MS * 4) @(posedge clock);
		$display("test overtravel done");
		modeSel_b <= 1'b0;
		evMs <= 16'h0005;
		stepMs <= 16'h0009;
		runCmd_b <= 1'b0;
		repeat (MS) @(posedge clock);
		@(negedge clock);
		cmpB(seqErrOut, 1'b1, "sequence error");
		cmpB(motorRunOut, 1'b0, "no run on error");
		@(posedge clock);
		runCmd_b <= 1'b1;
		evMs <= 16'h0014;
		pattern <= 5'($urandom);
		repeat (4) @(posedge clock);
		runCmd_b <= 1'b0;
		repeat (MS) @(posedge clock);
		@(negedge clock);
		cmpB(motorRunOut, 1'b1, "program start");
		cmpB(positionDoneOut, 1'b0, "done cleared");
		cmpS(28'(progOutputs), 28'(pattern), "outputs");
		cmpB(seqErrOut, 1'b0, "error cleared");
		@(posedge clock);
		posReached <= 1'b1;
		repeat (4) @(posedge clock);
		@(negedge clock);
		cmpB(positionDoneOut, 1'b1, "position done");
		$display("test program start done");
		test_done();
	end
endmodule
`default_nettype wire
